// *** pps_pkg.sv ***
// package: constants for the port pin function select block
package pps_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_PULL = 8'h08;
  localparam logic [7:0] OFS_PIN = 8'h0C;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // port geometry
  localparam int LINES = 6;
  localparam int LINE_RST = 5;
  localparam int LINE_OSC_OUT = 4;
  localparam int LINE_OSC_IN = 3;
  // config register fields
  localparam int CFG_CODE_W = 4;
  localparam int CFG_RST_EN_BIT = 4;
  localparam logic [3:0] CFG_CODE_RESET = 4'h2;
  localparam logic CFG_RST_EN_RESET = 1'b1;
  // status register fields
  localparam int ST_OSC_IN_BIT = 0;
  localparam int ST_OSC_OUT_BIT = 1;
  localparam int ST_RST_PIN_BIT = 2;
  localparam int ST_EXT_RST_BIT = 3;
  // clock source decode bounds, variant with data storage
  localparam logic [3:0] C4_XTAL_LO = 4'hA;
  localparam logic [3:0] C4_LF_LO = 4'h8;
  localparam logic [3:0] C4_ERC_LO = 4'h5;
  localparam logic [3:0] C4_IRC_LO = 4'h2;
  // clock source codes, variant without data storage
  localparam logic [2:0] C3_XTAL = 3'h7;
  localparam logic [2:0] C3_LF = 3'h6;
  localparam logic [2:0] C3_ERC = 3'h5;
  localparam logic [2:0] C3_IRC = 3'h4;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // clock source classes
  typedef enum logic [2:0] {SRC_XTAL, SRC_LF_XTAL, SRC_EXT_RC, SRC_INT_RC, SRC_EXT_CLK} pps_src_t;
endpackage : pps_pkg

// *** pps_pad_cell.sv ***
// pps_pad_cell: one port line with registered pad drive and input synchroniser
`timescale 1ns/10ps
`default_nettype none
module pps_pad_cell (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst_n,
  // role of the line
  input wire logic owned,
  input wire logic may_drive,
  input wire logic open_drain,
  // software settings
  input wire logic dir,
  input wire logic data,
  input wire logic pull_req,
  // pad
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  output logic pin_pullup_en,
  // synchronised value seen by software
  output logic line_value
);
  logic sync1_reg;
  logic sync2_reg;
  logic drive;
  logic pull;

  // drive only when the port owns the line; open drain pulls low only
  assign drive = owned & may_drive & dir & (~open_drain | ~data);
  assign pull = owned & pull_req & ~dir & ~open_drain;

  // pad registers tri-state at once on reset, clock or not
  always_ff @(posedge clock or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      pin_oe_n <= 1'b1;
      pin_out <= 1'b0;
      pin_pullup_en <= 1'b0;
    end else begin
      pin_oe_n <= ~drive;
      pin_out <= data & ~open_drain;
      pin_pullup_en <= pull;
    end
  end

  // two-stage input synchroniser, taken lines read zero
  always_ff @(posedge clock or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      line_value <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      line_value <= sync2_reg & owned;
    end
  end
endmodule : pps_pad_cell
`default_nettype wire

// *** pps_top.sv ***
// pps_top: port pin function select with register slave
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pps_top #(
  parameter bit HAS_STORAGE = 1'b1,
  parameter int ADDR_W = 8
) (
  // clock and power-on reset
  input wire logic clock,
  input wire logic arst_n,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port pads
  input wire logic [pps_pkg::LINES-1:0] pin_in,
  output logic [pps_pkg::LINES-1:0] pin_out,
  output logic [pps_pkg::LINES-1:0] pin_oe_n,
  output logic [pps_pkg::LINES-1:0] pin_pullup_en,
  // to the oscillator and reset logic
  output logic osc_amp_input_en,
  output logic osc_amp_output_en,
  output logic reset_pin_en,
  output logic sys_rst_n
);
  logic [pps_pkg::LINES-1:0] data_reg;
  logic [pps_pkg::LINES-1:0] dir_reg;
  logic [pps_pkg::LINES-1:0] pull_reg;
  logic [pps_pkg::CFG_CODE_W-1:0] code_reg;
  logic rst_en_reg;
  logic ext_rst_reg;
  logic pin_low1_reg;
  logic pin_low2_reg;
  logic rst1_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [pps_pkg::LINES-1:0] line_value;
  logic [pps_pkg::LINES-1:0] owned;
  logic [pps_pkg::LINES-1:0] may_drive;
  logic [pps_pkg::LINES-1:0] open_drain;
  pps_pkg::pps_src_t src;
  logic take_osc_in;
  logic take_osc_out;
  logic take_rst;
  logic comb_rst_n;

  // clock source class from the stored code
  always_comb begin
    src = pps_pkg::SRC_EXT_CLK;
    if (HAS_STORAGE) begin
      if (code_reg >= pps_pkg::C4_XTAL_LO) src = pps_pkg::SRC_XTAL;
      else if (code_reg >= pps_pkg::C4_LF_LO) src = pps_pkg::SRC_LF_XTAL;
      else if (code_reg >= pps_pkg::C4_ERC_LO) src = pps_pkg::SRC_EXT_RC;
      else if (code_reg >= pps_pkg::C4_IRC_LO) src = pps_pkg::SRC_INT_RC;
      else src = pps_pkg::SRC_EXT_CLK;
    end else begin
      case (code_reg[2:0])
        pps_pkg::C3_XTAL: src = pps_pkg::SRC_XTAL;
        pps_pkg::C3_LF: src = pps_pkg::SRC_LF_XTAL;
        pps_pkg::C3_ERC: src = pps_pkg::SRC_EXT_RC;
        pps_pkg::C3_IRC: src = pps_pkg::SRC_INT_RC;
        default: src = pps_pkg::SRC_EXT_CLK;
      endcase
    end
  end

  // line roles follow the stored config with no state of their own
  assign take_osc_out = (src == pps_pkg::SRC_XTAL) | (src == pps_pkg::SRC_LF_XTAL);
  assign take_osc_in = take_osc_out | (src == pps_pkg::SRC_EXT_RC) | (src == pps_pkg::SRC_EXT_CLK);
  assign take_rst = rst_en_reg;
  assign owned = {~take_rst, ~take_osc_out, ~take_osc_in, 3'h7};
  assign may_drive = {HAS_STORAGE, 5'h1F};
  assign open_drain = {1'b1, 5'h00};

  // reset pin low, when enabled, resets the port with no clock needed
  assign comb_rst_n = arst_n & ~(rst_en_reg & ~pin_in[pps_pkg::LINE_RST]);

  // reset release synchroniser, assertion is immediate
  always_ff @(posedge clock or negedge comb_rst_n) begin
    if (!comb_rst_n) begin
      rst1_reg <= 1'b0;
      sys_rst_n <= 1'b0;
    end else begin
      rst1_reg <= 1'b1;
      sys_rst_n <= rst1_reg;
    end
  end

  // six pad cells, one per port line
  genvar gi;
  generate
    for (gi = 0; gi < pps_pkg::LINES; gi++) begin : g_line
      pps_pad_cell u_pad (
        .clock(clock),
        .sys_rst_n(sys_rst_n),
        .owned(owned[gi]),
        .may_drive(may_drive[gi]),
        .open_drain(open_drain[gi]),
        .dir(dir_reg[gi]),
        .data(data_reg[gi]),
        .pull_req(pull_reg[gi]),
        .pin_in(pin_in[gi]),
        .pin_out(pin_out[gi]),
        .pin_oe_n(pin_oe_n[gi]),
        .pin_pullup_en(pin_pullup_en[gi]),
        .line_value(line_value[gi])
      );
    end
  endgenerate

  // role outputs towards oscillator and reset circuits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_amp_input_en <= 1'b0;
      osc_amp_output_en <= 1'b0;
      reset_pin_en <= 1'b0;
    end else begin
      osc_amp_input_en <= take_osc_in;
      osc_amp_output_en <= take_osc_out;
      reset_pin_en <= take_rst;
    end
  end

  // bus write path: address and data taken in either order
  logic aw_take;
  logic w_take;
  logic do_write;
  logic [7:0] wofs;
  logic wbyte;
  logic wmapped;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign wofs = 8'(awaddr_reg);
  assign wbyte = do_write & wstrb_reg[0];
  assign wmapped = (wofs == pps_pkg::OFS_DATA) | (wofs == pps_pkg::OFS_DIR) |
                   (wofs == pps_pkg::OFS_PULL) | (wofs == pps_pkg::OFS_PIN) |
                   (wofs == pps_pkg::OFS_CFG) | (wofs == pps_pkg::OFS_STAT);

  // write channel holding registers
  always_ff @(posedge clock or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pps_pkg::RESP_OKAY;
    end else begin
      if (aw_take) awaddr_reg <= s_axi_awaddr;
      if (w_take) wdata_reg <= s_axi_wdata;
      if (w_take) wstrb_reg <= s_axi_wstrb;
      aw_full_reg <= (aw_full_reg & ~do_write) | aw_take;
      w_full_reg <= (w_full_reg & ~do_write) | w_take;
      s_axi_awready <= ~((aw_full_reg & ~do_write) | aw_take);
      s_axi_wready <= ~((w_full_reg & ~do_write) | w_take);
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wmapped ? pps_pkg::RESP_OKAY : pps_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // port registers, cleared by any reset
  always_ff @(posedge clock or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      data_reg <= '0;
      dir_reg <= '0;
      pull_reg <= '0;
    end else if (wbyte) begin
      if (wofs == pps_pkg::OFS_DATA) data_reg <= wdata_reg[pps_pkg::LINES-1:0];
      if (wofs == pps_pkg::OFS_DIR) dir_reg <= wdata_reg[pps_pkg::LINES-1:0];
      if (wofs == pps_pkg::OFS_PULL) pull_reg <= wdata_reg[pps_pkg::LINES-1:0];
    end
  end

  // stored clock and reset config survives the reset pin
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      code_reg <= pps_pkg::CFG_CODE_RESET;
      rst_en_reg <= pps_pkg::CFG_RST_EN_RESET;
    end else if (wbyte && wofs == pps_pkg::OFS_CFG) begin
      code_reg <= wdata_reg[pps_pkg::CFG_CODE_W-1:0];
      rst_en_reg <= wdata_reg[pps_pkg::CFG_RST_EN_BIT];
    end
  end

  // sticky external reset flag, set wins over write-one clear
  logic ext_clr;
  assign ext_clr = wbyte & (wofs == pps_pkg::OFS_STAT) & wdata_reg[pps_pkg::ST_EXT_RST_BIT];
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_low1_reg <= 1'b0;
      pin_low2_reg <= 1'b0;
      ext_rst_reg <= 1'b0;
    end else begin
      pin_low1_reg <= ~pin_in[pps_pkg::LINE_RST];
      pin_low2_reg <= pin_low1_reg;
      if (pin_low2_reg & rst_en_reg) ext_rst_reg <= 1'b1;
      else if (ext_clr) ext_rst_reg <= 1'b0;
    end
  end

  // read path: one outstanding read, registered data
  logic [7:0] rofs;
  logic [31:0] rmux;
  logic rmapped;
  assign rofs = 8'(s_axi_araddr);
  assign rmapped = (rofs == pps_pkg::OFS_DATA) | (rofs == pps_pkg::OFS_DIR) |
                   (rofs == pps_pkg::OFS_PULL) | (rofs == pps_pkg::OFS_PIN) |
                   (rofs == pps_pkg::OFS_CFG) | (rofs == pps_pkg::OFS_STAT);
  always_comb begin
    rmux = 32'h0000_0000;
    case (rofs)
      pps_pkg::OFS_DATA: rmux[pps_pkg::LINES-1:0] = data_reg;
      pps_pkg::OFS_DIR: rmux[pps_pkg::LINES-1:0] = dir_reg;
      pps_pkg::OFS_PULL: rmux[pps_pkg::LINES-1:0] = pull_reg;
      pps_pkg::OFS_PIN: rmux[pps_pkg::LINES-1:0] = line_value;
      pps_pkg::OFS_CFG: begin
        rmux[pps_pkg::CFG_CODE_W-1:0] = code_reg;
        rmux[pps_pkg::CFG_RST_EN_BIT] = rst_en_reg;
      end
      pps_pkg::OFS_STAT: begin
        rmux[pps_pkg::ST_OSC_IN_BIT] = take_osc_in;
        rmux[pps_pkg::ST_OSC_OUT_BIT] = take_osc_out;
        rmux[pps_pkg::ST_RST_PIN_BIT] = take_rst;
        rmux[pps_pkg::ST_EXT_RST_BIT] = ext_rst_reg;
      end
      default: rmux = 32'h0000_0000;
    endcase
  end

  // read channel registers
  always_ff @(posedge clock or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pps_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rmux;
      s_axi_rresp <= rmapped ? pps_pkg::RESP_OKAY : pps_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : pps_top
`default_nettype wire

// *** pps_properties.sv ***
// pps_properties: concurrent checks on the pin function select ports
`timescale 1ns/10ps
`default_nettype none
module pps_checker (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // pads and roles
  input wire logic [pps_pkg::LINES-1:0] pin_in,
  input wire logic [pps_pkg::LINES-1:0] pin_out,
  input wire logic [pps_pkg::LINES-1:0] pin_oe_n,
  input wire logic [pps_pkg::LINES-1:0] pin_pullup_en,
  input wire logic osc_amp_input_en,
  input wire logic osc_amp_output_en,
  input wire logic reset_pin_en,
  input wire logic sys_rst_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // pad roles against reset and oscillator ownership
  a_pin_rst_float: assert property (reset_pin_en && !pin_in[5] |->
    &pin_oe_n && !(|pin_pullup_en) && !(|pin_out) && !sys_rst_n) else $error("pads live in reset");
  a_line5_opendrain: assert property (!pin_pullup_en[5] && !pin_out[5])
    else $error("line 5 pulled or driven high");
  a_rst_owns_line5: assert property (reset_pin_en |-> pin_oe_n[5])
    else $error("line 5 driven while reset input");
  a_osc_in_float: assert property (osc_amp_input_en |-> pin_oe_n[3] && !pin_pullup_en[3])
    else $error("line 3 used while taken");
  a_osc_out_float: assert property (osc_amp_output_en |-> pin_oe_n[4] && !pin_pullup_en[4])
    else $error("line 4 used while taken");
  a_osc_pair: assert property (osc_amp_output_en |-> osc_amp_input_en)
    else $error("line 4 taken without line 3");
  a_roles_steady: assert property ($changed({osc_amp_input_en, osc_amp_output_en, reset_pin_en})
    && $past(sys_rst_n) |-> $past(s_axi_bvalid)) else $error("role changed without write");
  // bus answers
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule : pps_checker
bind pps_top pps_checker i_checker (.clock, .arst_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .pin_in, .pin_out,
  .pin_oe_n, .pin_pullup_en, .osc_amp_input_en, .osc_amp_output_en, .reset_pin_en, .sys_rst_n);
`default_nettype wire

// *** pps_board.sv ***
// pps_board: board model with reset switch, pull-ups and floating lines
`timescale 1ns/10ps
`default_nettype none
module pps_board (
  // clock and reset switch
  input wire logic clock,
  input wire logic rst_low,
  // device pads
  input wire logic [pps_pkg::LINES-1:0] pin_out,
  input wire logic [pps_pkg::LINES-1:0] pin_oe_n,
  input wire logic [pps_pkg::LINES-1:0] pin_pullup_en,
  output logic [pps_pkg::LINES-1:0] pin_in
);
  logic float_q = 1'b0;
  // undriven unpulled lines wander every cycle
  always @(posedge clock) float_q <= ~float_q;
  // pad levels from every party
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (pin_pullup_en[i] | float_q);
    end
    pin_in[5] = !(rst_low || !pin_oe_n[5]); // resistor pull-up, switch to ground
  end
endmodule : pps_board
`default_nettype wire

// *** pps_tb.sv ***
// pps_tb: self-checking bench for the pin function select block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock, arst_n, rst_low;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, v, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, dir, dat, pul, eoe, msk, exv;
  logic osc_amp_input_en, osc_amp_output_en, reset_pin_en, sys_rst_n;
  int n_fail = 0;
  int n_tests = 0;
  pps_top i_dut (.clock, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pin_in, .pin_out, .pin_oe_n, .pin_pullup_en, .osc_amp_input_en,
    .osc_amp_output_en, .reset_pin_en, .sys_rst_n);
  pps_board i_board (.clock, .rst_low, .pin_out, .pin_oe_n, .pin_pullup_en, .pin_in);
  // clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // helpers for stimulus and expectations
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : next_rand
  function automatic logic [1:0] exp_role(input logic [3:0] c);
    if (c >= 4'h8) return 2'h3;
    if (c >= 4'h5 || c <= 4'h1) return 2'h1;
    return 2'h0;
  endfunction : exp_role
  task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val
  task automatic chk_resp(input string what, input logic [1:0] e, input logic [1:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk_resp
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // bus master: write, then read
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= wd;
    s_axi_wvalid <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    @(posedge clock);
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge clock);
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // watchdog
  initial begin
    #100000;
    n_fail++;
    $display("watchdog expired");
    give_verdict();
  end
  // main sequence
  initial begin
    {arst_n, rst_low, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    seed = 32'h000121FF;
    repeat (12) @(posedge clock);
    chk_val("pads in reset", 32'h3F, {26'h0, pin_oe_n});
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    axi_rd(pps_pkg::OFS_CFG, d, r);
    chk_val("config reset", 32'h12, d);
    axi_rd(pps_pkg::OFS_STAT, d, r);
    chk_val("status reset", 32'h4, d);
    axi_rd(8'h18, d, r);
    chk_resp("unmapped read", pps_pkg::RESP_SLVERR, r);
    $display("test reset values done");
    for (int c = 0; c < 16; c++) begin
      axi_wr(pps_pkg::OFS_CFG, 32'h10 | 32'(c), r);
      repeat (2) @(posedge clock);
      chk_val("roles", {30'h0, exp_role(c[3:0])}, {30'h0, osc_amp_output_en, osc_amp_input_en});
      chk_val("reset role", 32'h1, {31'h0, reset_pin_en});
      axi_rd(pps_pkg::OFS_STAT, d, r);
      chk_val("status roles", {29'h0, 1'b1, exp_role(c[3:0])}, d & 32'h7);
    end
    $display("test clock source codes done");
    axi_wr(pps_pkg::OFS_CFG, 32'h2, r);
    for (int i = 0; i < 20; i++) begin
      v = next_rand();
      if (i == 0) v = 32'h0000003F;
      if (i == 1) v = 32'h0003F000;
      {pul, dat, dir} = v[17:0];
      axi_wr(pps_pkg::OFS_DIR, {26'h0, dir}, r);
      axi_wr(pps_pkg::OFS_DATA, {26'h0, dat}, r);
      axi_wr(pps_pkg::OFS_PULL, {26'h0, pul}, r);
      repeat (4) @(posedge clock);
      eoe = {!(dir[5] && !dat[5]), ~dir[4:0]};
      chk_val("drive enables", {26'h0, eoe}, {26'h0, pin_oe_n});
      chk_val("pull-ups", {27'h0, ~dir[4:0] & pul[4:0]}, {26'h0, pin_pullup_en});
      chk_val("driven levels", {26'h0, dat & ~eoe}, {26'h0, pin_out & ~pin_oe_n});
      msk = {1'b1, dir[4:0] | pul[4:0]};
      // driven lines read their data, pulled inputs read high, line 5 low only when driven
      exv = {eoe[5], (dir[4:0] & dat[4:0]) | (~dir[4:0] & pul[4:0])} & msk;
      axi_rd(pps_pkg::OFS_PIN, d, r);
      chk_val("pin values", {26'h0, exv}, d & {26'h0, msk});
    end
    chk_val("port use keeps running", 32'h1, {31'h0, sys_rst_n});
    chk_val("port role", 32'h0, {31'h0, reset_pin_en});
    $display("test port traffic done");
    axi_wr(pps_pkg::OFS_DIR, 32'h1F, r); // release line 5 before it becomes the reset input
    axi_wr(pps_pkg::OFS_CFG, 32'h12, r);
    repeat (3) @(posedge clock);
    rst_low <= 1'b1;
    #2;
    chk_val("pin reset float", 32'h3F, {26'h0, pin_oe_n});
    repeat (6) @(posedge clock);
    rst_low <= 1'b0;
    repeat (4) @(posedge clock);
    axi_rd(pps_pkg::OFS_STAT, d, r);
    chk_val("reset seen flag", 32'h8, d & 32'h8);
    axi_rd(pps_pkg::OFS_CFG, d, r);
    chk_val("config kept", 32'h12, d);
    axi_wr(pps_pkg::OFS_STAT, 32'h8, r);
    axi_rd(pps_pkg::OFS_STAT, d, r);
    chk_val("flag cleared", 32'h0, d & 32'h8);
    axi_wr(8'h18, 32'h0, r);
    chk_resp("unmapped write", pps_pkg::RESP_SLVERR, r);
    $display("test pin reset done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
